// ---- rtl/spt_top.sv ----
// parallel slave port with port d latch, port e strobes and register file
//
// How it works
// - input_full_flag at bit 7 shows a host word awaiting a cpu read.
// - output_full_flag at bit 6 high until host reads cpu's last word.
// - host write while input word unread sets sticky overrun bit 5.
// - bit 4 selects slave port mode (1) or general purpose io (0).
// - bits 2:0 are port e pin directions, one means input.
// - reset loads control register with flags and mode clear, dir all ones.
// - in slave mode the host reads and writes port d without our clock; here strobes and data pass two-flop synchronisers on clk_sys.
// - port d appears to the host as one 8-bit read/write latch.
// - slave mode turns port e pins into read, write and select inputs.
// - host write happens when select and write strobe are first both low.
// - host read happens when select and read strobe are first both low.
// - selected and read strobe low means read; high means no read.
// - selected and write strobe low means write; high means no write.
// - select high makes the port ignore both strobes.
// - port e pins set analog read back as zero.
// - after reset port e pins stay analog until reconfigured.
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "spt_map.svh"
module spt_top (
	input wire logic clk_sys,
	input wire logic reset,
	input wire spt_pkg::spt_wb_req_s wb_req,
	output spt_pkg::spt_wb_rsp_s wb_rsp,
	input wire logic [7:0] pd_in,
	input wire logic [2:0] pe_in,
	output spt_pkg::spt_pin_s pins,
	output logic irq
);
	import spt_pkg::*;

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [7:0] pd_sync;
	logic [2:0] pe_sync;

	// data and strobes share latency, so data is stable at detection
	spt_sync #(.WIDTH(8), .RST_VAL(`SPT_RST_PD_SYNC)) u_sync_pd (
		.clk_sys(clk_sys),
		.reset(reset),
		.d(pd_in),
		.q(pd_sync)
	);

	spt_sync #(.WIDTH(3), .RST_VAL(`SPT_RST_PE_SYNC)) u_sync_pe (
		.clk_sys(clk_sys),
		.reset(reset),
		.d(pe_in),
		.q(pe_sync)
	);

	// ************************************************************
	// state
	// ************************************************************
	logic in_full_q, in_full_d;
	logic out_full_q, out_full_d;
	logic ovr_q, ovr_d;
	logic mode_q, mode_d;
	logic [2:0] dir_q, dir_d;
	logic [7:0] in_latch_q, in_latch_d;
	logic [7:0] out_latch_q, out_latch_d;
	logic [2:0] pe_latch_q, pe_latch_d;
	logic irqf_q, irqf_d;
	logic irqe_q, irqe_d;
	logic [7:0] analog_q, analog_d;
	spt_host_e host_q, host_d;
	spt_wb_rsp_s rsp_q, rsp_d;
	spt_pin_s pins_q, pins_d;
	logic irq_q, irq_d;

	// ************************************************************
	// analog gating and strobe decode
	// ************************************************************
	wire logic e_digital = (analog_q[3:0] >= `SPT_ANA_E_DIGITAL);
	// analog pins read as zero to software
	wire logic [2:0] pe_seen = e_digital ? pe_sync : 3'h0;
	// analog pins count as idle strobes so no phantom access occurs
	wire logic [2:0] strobe_n = e_digital ? pe_sync : 3'h7;
	wire logic selected = mode_q & ~strobe_n[`SPT_PE_CS];
	wire logic rd_low = selected & ~strobe_n[`SPT_PE_RD];
	wire logic wr_low = selected & ~strobe_n[`SPT_PE_WR];
	wire logic host_idle = (host_q == SPT_ST_IDLE);
	wire logic host_wr_ev = host_idle & wr_low;
	wire logic host_rd_ev = host_idle & ~wr_low & rd_low;

	// ************************************************************
	// host access tracker
	// ************************************************************
	// an access stays open until its strobe releases, one event each
	always_comb begin
		host_d = host_q;
		unique case (host_q)
			SPT_ST_IDLE: begin
				if (wr_low) begin
					host_d = SPT_ST_WRITE;
				end else if (rd_low) begin
					host_d = SPT_ST_READ;
				end
			end
			SPT_ST_READ: begin
				if (!rd_low) begin
					host_d = SPT_ST_IDLE;
				end
			end
			SPT_ST_WRITE: begin
				if (!wr_low) begin
					host_d = SPT_ST_IDLE;
				end
			end
		endcase
	end

	// ************************************************************
	// bus decode
	// ************************************************************
	wire logic bus_req = wb_req.cyc & wb_req.stb;
	// effects land on the edge where the master sees ack
	wire logic bus_fire = bus_req & rsp_q.ack;
	wire logic bus_wr = bus_fire & wb_req.we & wb_req.sel[0];
	wire logic bus_rd = bus_fire & ~wb_req.we;
	wire logic [7:0] idx = wb_req.adr[9:2];
	wire logic [7:0] wdat = wb_req.dat[7:0];
	wire logic hit_pd = (idx == `SPT_IDX_PORT_D);
	wire logic hit_pe = (idx == `SPT_IDX_PORT_E);
	wire logic hit_if = (idx == `SPT_IDX_IRQ_FLAGS);
	wire logic hit_dc = (idx == `SPT_IDX_DIR_CTRL);
	wire logic hit_ie = (idx == `SPT_IDX_IRQ_EN);
	wire logic hit_an = (idx == `SPT_IDX_ANALOG);
	wire logic cpu_rd_pd = bus_rd & hit_pd;
	wire logic cpu_wr_pd = bus_wr & hit_pd;
	wire logic cpu_wr_pe = bus_wr & hit_pe;
	wire logic cpu_wr_if = bus_wr & hit_if;
	wire logic cpu_wr_dc = bus_wr & hit_dc;
	wire logic cpu_wr_ie = bus_wr & hit_ie;
	wire logic cpu_wr_an = bus_wr & hit_an;
	wire logic ovr_clr = cpu_wr_dc & ~wdat[`SPT_BIT_OVERRUN];
	wire logic irqf_clr = cpu_wr_if & ~wdat[`SPT_BIT_IRQ];

	// ************************************************************
	// read data
	// ************************************************************
	wire logic [7:0] dir_ctrl_rd = {in_full_q, out_full_q, ovr_q, mode_q,
		1'b0, dir_q};
	// slave mode returns the host's word, otherwise the live pins
	wire logic [7:0] pd_rd = mode_q ? in_latch_q : pd_sync;
	wire logic [7:0] rdata = hit_pd ? pd_rd :
		hit_pe ? {5'h00, pe_seen} :
		hit_if ? {irqf_q, 7'h00} :
		hit_dc ? dir_ctrl_rd :
		hit_ie ? {irqe_q, 7'h00} :
		hit_an ? analog_q : 8'h00;

	// ************************************************************
	// next values
	// ************************************************************
	// set wins over clear for every hardware flag
	assign in_full_d = host_wr_ev | (in_full_q & ~cpu_rd_pd);
	assign out_full_d = (cpu_wr_pd & mode_q)
		| (out_full_q & ~host_rd_ev);
	assign ovr_d = (host_wr_ev & in_full_q & ~cpu_rd_pd)
		| (ovr_q & ~ovr_clr);
	assign mode_d = cpu_wr_dc ? wdat[`SPT_BIT_MODE] : mode_q;
	assign dir_d = cpu_wr_dc ? wdat[2:0] : dir_q;
	assign in_latch_d = host_wr_ev ? pd_sync : in_latch_q;
	assign out_latch_d = cpu_wr_pd ? wdat : out_latch_q;
	assign pe_latch_d = cpu_wr_pe ? wdat[2:0] : pe_latch_q;
	assign irqf_d = host_wr_ev | host_rd_ev | (irqf_q & ~irqf_clr);
	assign irqe_d = cpu_wr_ie ? wdat[`SPT_BIT_IRQ] : irqe_q;
	assign analog_d = cpu_wr_an ? wdat : analog_q;
	assign irq_d = irqf_q & irqe_q;
	assign rsp_d.ack = bus_req & ~rsp_q.ack;
	assign rsp_d.dat = (bus_req & ~rsp_q.ack) ? {24'h000000, rdata}
		: rsp_q.dat;
	assign pins_d.pd_out = out_latch_q;
	// drive port d only while a host read is open
	assign pins_d.pd_oe_n = {8{host_d != SPT_ST_READ}};
	assign pins_d.pe_out = pe_latch_q;
	assign pins_d.pe_oe_n = mode_q ? 3'h7 : dir_q;

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			in_full_q <= 1'b0;
			out_full_q <= 1'b0;
			ovr_q <= 1'b0;
			mode_q <= 1'b0;
			dir_q <= `SPT_RST_DIR;
		end else begin
			in_full_q <= in_full_d;
			out_full_q <= out_full_d;
			ovr_q <= ovr_d;
			mode_q <= mode_d;
			dir_q <= dir_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			in_latch_q <= 8'h00;
			out_latch_q <= 8'h00;
			pe_latch_q <= 3'h0;
			analog_q <= `SPT_RST_ANALOG;
			host_q <= SPT_ST_IDLE;
		end else begin
			in_latch_q <= in_latch_d;
			out_latch_q <= out_latch_d;
			pe_latch_q <= pe_latch_d;
			analog_q <= analog_d;
			host_q <= host_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			irqf_q <= 1'b0;
			irqe_q <= 1'b0;
			irq_q <= 1'b0;
			rsp_q <= '0;
			pins_q <= {8'h00, 8'hFF, 3'h0, 3'h7};
		end else begin
			irqf_q <= irqf_d;
			irqe_q <= irqe_d;
			irq_q <= irq_d;
			rsp_q <= rsp_d;
			pins_q <= pins_d;
		end
	end

	assign wb_rsp = rsp_q;
	assign pins = pins_q;
	assign irq = irq_q;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	a_in_full_set: assert property (
		host_wr_ev |=> in_full_q && (in_latch_q == $past(pd_sync)))
		else $error("input full not set by host write");

	a_in_full_clr: assert property (
		cpu_rd_pd && !host_wr_ev |=> !in_full_q)
		else $error("input full not cleared by cpu read");

	a_out_full_life: assert property (
		(cpu_wr_pd && mode_q) || (out_full_q && !host_rd_ev)
		|=> out_full_q)
		else $error("output full dropped before host read");

	a_out_full_clr: assert property (
		host_rd_ev && !cpu_wr_pd |=> !out_full_q)
		else $error("output full not cleared by host read");

	a_overrun_set: assert property (
		host_wr_ev && in_full_q && !cpu_rd_pd |=> ovr_q)
		else $error("overrun not flagged");

	a_overrun_sticky: assert property (
		ovr_q && !ovr_clr |=> ovr_q)
		else $error("overrun cleared without software");

	a_unselected_idle: assert property (
		!selected [*2] |-> ##1 host_q == SPT_ST_IDLE)
		else $error("access while not selected");

	a_single_event: assert property (
		host_wr_ev |=> !host_wr_ev && !host_rd_ev)
		else $error("host access counted twice");

	a_read_drive: assert property (
		host_rd_ev |=> pins_q.pd_oe_n == 8'h00 ##1 pins_q.pd_oe_n == 8'h00
		|| !rd_low)
		else $error("port d not driven during host read");

	a_pins_inputs: assert property (
		mode_q |=> pins_q.pe_oe_n == 3'h7)
		else $error("port e driven in slave mode");

	a_reset_value: assert property (
		$fell(reset) |-> dir_ctrl_rd == 8'h07 && !e_digital)
		else $error("control register reset value wrong");

	a_irq_path: assert property (
		(host_wr_ev || host_rd_ev) && irqe_q && !cpu_wr_ie |-> ##2 irq)
		else $error("interrupt not raised for host access");

	a_ack_pulse: assert property (
		rsp_q.ack |=> !rsp_q.ack)
		else $error("ack held longer than one cycle");

	c_host_write: cover property (host_wr_ev ##[1:20] cpu_rd_pd);
	c_host_read: cover property (cpu_wr_pd ##[1:20] host_rd_ev);
	c_overrun: cover property (host_wr_ev && in_full_q);
	c_set_clear: cover property (host_wr_ev && cpu_rd_pd);
endmodule

// ---- rtl/spt_map.svh ----
// register indices, field positions and reset values of the slave port
`ifndef SPT_MAP_SVH
`define SPT_MAP_SVH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define SPT_IDX_PORT_D 8'h08
`define SPT_IDX_PORT_E 8'h09
`define SPT_IDX_IRQ_FLAGS 8'h0C
`define SPT_IDX_DIR_CTRL 8'h89
`define SPT_IDX_IRQ_EN 8'h8C
`define SPT_IDX_ANALOG 8'h9F

// ************************************************************
// field positions
// ************************************************************
`define SPT_BIT_IN_FULL 7
`define SPT_BIT_OUT_FULL 6
`define SPT_BIT_OVERRUN 5
`define SPT_BIT_MODE 4
`define SPT_BIT_IRQ 7
`define SPT_PE_RD 0
`define SPT_PE_WR 1
`define SPT_PE_CS 2

// ************************************************************
// reset values and decode thresholds
// ************************************************************
`define SPT_RST_DIR 3'h7
`define SPT_RST_ANALOG 8'h00
`define SPT_RST_PD_SYNC 8'h00
`define SPT_RST_PE_SYNC 3'h7
`define SPT_ANA_E_DIGITAL 4'h8

`endif

// ---- rtl/spt_pkg.sv ----
// types shared by the slave port design
package spt_pkg;

	// ************************************************************
	// bus carriers
	// ************************************************************
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [9:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} spt_wb_req_s;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} spt_wb_rsp_s;

	// ************************************************************
	// pin drivers
	// ************************************************************
	typedef struct packed {
		logic [7:0] pd_out;
		logic [7:0] pd_oe_n;
		logic [2:0] pe_out;
		logic [2:0] pe_oe_n;
	} spt_pin_s;

	// ************************************************************
	// host access tracking
	// ************************************************************
	typedef enum logic [2:0] {
		SPT_ST_IDLE = 3'b001,
		SPT_ST_READ = 3'b010,
		SPT_ST_WRITE = 3'b100
	} spt_host_e;

endpackage

// ---- rtl/spt_sync.sv ----
// two flip-flop synchroniser, one lane per bit
`timescale 1ns/1ps
module spt_sync #(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	// ************************************************************
	// per-bit stages
	// ************************************************************
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_lane
			logic meta_q;
			logic sync_q;
			// first stage feeds only the second
			always_ff @(posedge clk_sys) begin
				if (reset) begin
					meta_q <= RST_VAL[i];
					sync_q <= RST_VAL[i];
				end else begin
					meta_q <= d[i];
					sync_q <= meta_q;
				end
			end
			assign q[i] = sync_q;
		end
	endgenerate
endmodule

// ---- verif/spt_host.sv ----
// behavioural external processor driving the slave port pins
`timescale 1ns/1ps
module spt_host (
	input wire logic clk_sys,
	input wire spt_pkg::spt_pin_s pins,
	output logic [7:0] pd_in,
	output logic [2:0] pe_in
);
	import spt_pkg::*;
	// ****************
	// pin levels and host cycles
	// ****************
	logic [7:0] bus_q = 8'hFF;
	logic [2:0] strb_q = 3'h7;
	// a released bus shows the inverse, so stale data cannot match
	assign pd_in = (~pins.pd_oe_n & pins.pd_out) | (pins.pd_oe_n & bus_q);
	assign pe_in = (~pins.pe_oe_n & pins.pe_out) | (pins.pe_oe_n & strb_q);
	task automatic access(input logic wr, input logic sel_n,
		input logic [7:0] wd, output logic [7:0] rdat);
		@(posedge clk_sys);
		if (wr) bus_q <= wd;
		repeat (4) @(posedge clk_sys);
		strb_q <= {sel_n, ~wr, wr};
		// strobe held well past the three cycle minimum
		repeat (6) @(posedge clk_sys);
		rdat = pd_in;
		strb_q <= 3'h7;
		repeat (2) @(posedge clk_sys);
		bus_q <= ~bus_q;
		repeat (4) @(posedge clk_sys);
	endtask
endmodule

// ---- verif/parallel_slave_port_tb.sv ----
// self-checking bench for the parallel slave port
`timescale 1ns/1ps
module parallel_slave_port_tb;
	import spt_pkg::*;
	// ****************
	// clock, reset and instances
	// ****************
	typedef struct {
		logic we;
		logic [9:0] adr;
		logic [7:0] wd;
		logic [7:0] exp;
	} spt_row_s;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	spt_wb_req_s wb_req = '0;
	spt_wb_rsp_s wb_rsp;
	spt_pin_s pins;
	logic [7:0] pd_in;
	logic [2:0] pe_in;
	logic irq;
	logic [31:0] rd;
	logic [7:0] hd;
	int fails = 0;
	int checks_done = 0;
	spt_row_s rows [10] = '{
		'{1'b0, 10'h224, 8'h00, 8'h07},
		'{1'b0, 10'h27C, 8'h00, 8'h00},
		'{1'b0, 10'h030, 8'h00, 8'h00},
		'{1'b0, 10'h230, 8'h00, 8'h00},
		'{1'b0, 10'h024, 8'h00, 8'h00},
		'{1'b1, 10'h3FC, 8'hFF, 8'h00},
		'{1'b1, 10'h27C, 8'h08, 8'h08},
		'{1'b0, 10'h024, 8'h00, 8'h07},
		'{1'b1, 10'h224, 8'hFF, 8'h17},
		'{1'b1, 10'h230, 8'h80, 8'h80}
	};
	always #25 clk_sys = ~clk_sys;
	spt_top spt_top_i (.clk_sys(clk_sys), .reset(reset), .wb_req(wb_req),
		.wb_rsp(wb_rsp), .pd_in(pd_in), .pe_in(pe_in), .pins(pins),
		.irq(irq));
	spt_host spt_host_i (.clk_sys(clk_sys), .pins(pins), .pd_in(pd_in),
		.pe_in(pe_in));
	// ****************
	// tasks
	// ****************
	task automatic chk(input string s, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic wb(input logic we, input logic [9:0] a,
		input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge clk_sys);
		wb_req <= '{1'b1, 1'b1, we, a, 4'h1, {24'h0, wd}};
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_rsp.ack !== 1'b1 && n < 20);
		rd = wb_rsp.dat;
		wb_req <= '0;
		if (wb_rsp.ack !== 1'b1) begin
			fails++;
			stop_test();
		end
	endtask
	task automatic rr(input logic [9:0] a, input logic [7:0] e,
		input string s);
		wb(1'b0, a, 8'h00);
		chk(s, rd, {24'h0, e});
	endtask
	// ****************
	// sequence
	// ****************
	initial begin
		repeat (10) @(posedge clk_sys);
		reset <= 1'b0;
		// rows: reset values, unmapped place, read-only bits, setup
		foreach (rows[i]) begin
			if (rows[i].we) wb(1'b1, rows[i].adr, rows[i].wd);
			rr(rows[i].adr, rows[i].exp, "row");
		end
		$display("register rows done");
		spt_host_i.access(1'b1, 1'b0, 8'h5A, hd);
		rr(10'h224, 8'h97, "ctrl hw");
		rr(10'h030, 8'h80, "irq flag");
		chk("irq line", {31'h0, irq}, 32'h1);
		spt_host_i.access(1'b1, 1'b0, 8'hA5, hd);
		rr(10'h224, 8'hB7, "ctrl ovr");
		rr(10'h020, 8'hA5, "port d");
		rr(10'h224, 8'h37, "ctrl rd");
		wb(1'b1, 10'h224, 8'hD7);
		rr(10'h224, 8'h17, "ovr clr");
		wb(1'b1, 10'h030, 8'h00);
		repeat (2) @(posedge clk_sys);
		chk("irq off", {31'h0, irq}, 32'h0);
		$display("host write test done");
		wb(1'b1, 10'h020, 8'h3C);
		rr(10'h224, 8'h57, "obf set");
		spt_host_i.access(1'b0, 1'b0, 8'h00, hd);
		chk("host rd", {24'h0, hd}, 32'h3C);
		chk("pd rel", {24'h0, pins.pd_oe_n}, 32'hFF);
		rr(10'h224, 8'h17, "obf clr");
		$display("host read test done");
		spt_host_i.access(1'b1, 1'b1, 8'h11, hd);
		rr(10'h224, 8'h17, "desel");
		wb(1'b1, 10'h224, 8'h07);
		spt_host_i.access(1'b1, 1'b0, 8'h22, hd);
		rr(10'h224, 8'h07, "gpio");
		wb(1'b1, 10'h224, 8'h00);
		wb(1'b1, 10'h024, 8'h05);
		repeat (4) @(posedge clk_sys);
		rr(10'h024, 8'h05, "pe loop");
		chk("pe out", {29'h0, pins.pe_out}, 32'h5);
		chk("pe oe", {29'h0, pins.pe_oe_n}, 32'h0);
		wb(1'b1, 10'h224, 8'h10);
		repeat (2) @(posedge clk_sys);
		chk("pe slave", {29'h0, pins.pe_oe_n}, 32'h7);
		$display("ignored access test done");
		wb(1'b1, 10'h224, 8'h17);
		spt_host_i.access(1'b1, 1'b0, 8'h33, hd);
		@(posedge clk_sys);
		reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		rr(10'h224, 8'h07, "rst ctrl");
		rr(10'h27C, 8'h00, "rst ana");
		$display("mid-run reset test done");
		stop_test();
	end
endmodule
